// file: design/cgr_consts.vh
// constants for the clock generator status and identification register page
`ifndef CGR_CONSTS_VH
`define CGR_CONSTS_VH
// ***************************************************************
// register offsets (low byte)
// ***************************************************************
`define CGR_OFS_DIE_REVISION 8'h00
`define CGR_OFS_PAGE_SELECT 8'h01
`define CGR_OFS_PART_LOW 8'h02
`define CGR_OFS_PART_HIGH 8'h03
`define CGR_OFS_SPEED_GRADE 8'h04
`define CGR_OFS_DEVICE_REV 8'h05
`define CGR_OFS_TOOL0 8'h06
`define CGR_OFS_TOOL1 8'h07
`define CGR_OFS_TOOL2 8'h08
`define CGR_OFS_TEMP_GRADE 8'h09
`define CGR_OFS_PACKAGE 8'h0a
`define CGR_OFS_TARGET_ADDR 8'h0b
`define CGR_OFS_LIVE_STATUS 8'h0c
`define CGR_OFS_INPUT_LOSS 8'h0d
`define CGR_OFS_STICKY_FAULT 8'h11
`define CGR_OFS_STICKY_LOSS 8'h12
`define CGR_OFS_FAULT_MASK 8'h17
`define CGR_OFS_READY 8'hff
// ***************************************************************
// field layouts and reset values
// ***************************************************************
`define CGR_FAULT_BITS 8'h2f
`define CGR_LOSS_BITS 8'h0f
`define CGR_ADDR_FIELD 8'h7c
`define CGR_RST_PAGE 8'h00
`define CGR_RST_ADDR_UPPER 5'h1d
`define CGR_RST_MASK 8'h00
`endif

// file: design/cgr_regs.v
// status and identification register page of the clock generator
`timescale 1ns/1ps
`include "cgr_consts.vh"
module cgr_regs #(
  parameter [3:0] DIE_REVISION = 4'h0,
  // base part digits, value arbitrary
  parameter [15:0] BASE_PART_DIGITS = 16'h1234,
  parameter [7:0] SPEED_GRADE = 8'h00,
  parameter [7:0] DEVICE_REVISION = 8'h00,
  parameter [23:0] TOOL_VERSION = 24'h00_0000,
  parameter [7:0] TEMP_GRADE = 8'h00,
  parameter [7:0] PACKAGE_CODE = 8'h00
) (
  input wire clock,
  input wire rstn,
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_addr_hit,
  output wire [7:0] current_page,
  input wire calibration_in_progress,
  input wire crystal_input_signal_loss,
  input wire detector_reference_missing,
  input wire pll_unlocked,
  input wire bus_timeout,
  input wire [3:0] per_input_signal_loss,
  input wire device_ready,
  input wire address_select_pin_high,
  input wire address_select_pin_low,
  output reg [6:0] serial_target_address,
  output reg irq_n
);
  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  // status lines come from analog monitors on other clocks; three stages,
  // and a change is taken only when stages two and three agree
  // bit map: 0..4 status, 8:5 input loss, 9 ready, 10 pin low, 11 pin high
  wire [11:0] raw_w;
  reg [11:0] s1_q;
  reg [11:0] s2_q;
  reg [11:0] s3_q;
  reg [11:0] clean_q;
  reg [11:0] clean_d;
  integer i;
  assign raw_w = {address_select_pin_high, address_select_pin_low, device_ready, per_input_signal_loss,
                  bus_timeout, pll_unlocked, detector_reference_missing, crystal_input_signal_loss,
                  calibration_in_progress};
  // sync chain
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= 12'h000;
      s2_q <= 12'h000;
      s3_q <= 12'h000;
    end
    else
    begin
      s1_q <= raw_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // agreement filter
  always @*
  begin
    for (i = 0; i < 12; i = i + 1)
      clean_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : clean_q[i];
  end
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      clean_q <= 12'h000;
    else
      clean_q <= clean_d;
  end
  // ***************************************************************
  // live views
  // ***************************************************************
  wire [7:0] live_fault_w;
  wire [7:0] live_loss_w;
  // bit 4 of the status byte is unused and reads zero
  assign live_fault_w = {2'b00, clean_q[4], 1'b0, clean_q[3:0]};
  assign live_loss_w = {4'h0, clean_q[8:5]};
  // ***************************************************************
  // write decode
  // ***************************************************************
  // low byte picks the register; page 0 holds everything except the page
  // select and ready byte, which appear on every page
  function is_reg;
    input [15:0] addr;
    input [7:0] page;
    input [7:0] ofs;
    begin
      is_reg = (addr[15:8] == page) && (addr[7:0] == ofs);
    end
  endfunction
  reg [7:0] page_q;
  reg [4:0] addr_upper_q;
  reg [7:0] sticky_fault_q;
  reg [7:0] sticky_loss_q;
  reg [7:0] mask_q;
  wire on_page0;
  wire wr_page;
  wire wr_addr;
  wire wr_sfault;
  wire wr_sloss;
  wire wr_mask;
  assign on_page0 = (page_q == 8'h00);
  assign wr_page = reg_wr && (reg_addr[7:0] == `CGR_OFS_PAGE_SELECT);
  assign wr_addr = reg_wr && on_page0 && is_reg(reg_addr, 8'h00, `CGR_OFS_TARGET_ADDR);
  assign wr_sfault = reg_wr && on_page0 && is_reg(reg_addr, 8'h00, `CGR_OFS_STICKY_FAULT);
  assign wr_sloss = reg_wr && on_page0 && is_reg(reg_addr, 8'h00, `CGR_OFS_STICKY_LOSS);
  assign wr_mask = reg_wr && on_page0 && is_reg(reg_addr, 8'h00, `CGR_OFS_FAULT_MASK);
  // ***************************************************************
  // writable state
  // ***************************************************************
  // page select: the upper address byte of the access must equal the
  // current page; the page byte itself is the current page number
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      page_q <= `CGR_RST_PAGE;
    else if (wr_page && reg_addr[15:8] == page_q)
      page_q <= reg_wdata;
  end
  assign current_page = page_q;
  // target address upper bits and interrupt masks
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_upper_q <= `CGR_RST_ADDR_UPPER;
      mask_q <= `CGR_RST_MASK;
    end
    else
    begin
      if (wr_addr)
        addr_upper_q <= reg_wdata[6:2];
      if (wr_mask)
        mask_q <= reg_wdata & `CGR_FAULT_BITS;
    end
  end
  // sticky flags: a set in the same cycle as a clearing write wins, so
  // no event is lost; writing one keeps a flag as it is
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sticky_fault_q <= 8'h00;
      sticky_loss_q <= 8'h00;
    end
    else
    begin
      sticky_fault_q <= (wr_sfault ? (sticky_fault_q & reg_wdata) : sticky_fault_q)
                        | live_fault_w;
      sticky_loss_q <= (wr_sloss ? (sticky_loss_q & reg_wdata) : sticky_loss_q)
                       | live_loss_w;
    end
  end
  // serial target address: upper bits from register, lower from pins
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      serial_target_address <= 7'h00;
    else
      serial_target_address <= {addr_upper_q, clean_q[11:10]};
  end
  // interrupt output, registered to keep it glitch free
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irq_n <= 1'b1;
    else
      irq_n <= ~(|(sticky_fault_q & ~mask_q & `CGR_FAULT_BITS));
  end
  // ***************************************************************
  // read mux
  // ***************************************************************
  // read-only fields are parameters or live views, so writes to them have
  // no target and fall away
  reg [7:0] rd_d;
  reg hit_d;
  always @*
  begin
    rd_d = 8'h00;
    hit_d = 1'b1;
    if (reg_addr[15:8] != page_q)
      hit_d = 1'b0;
    else if (reg_addr[7:0] == `CGR_OFS_PAGE_SELECT)
      rd_d = page_q;
    else if (reg_addr[7:0] == `CGR_OFS_READY)
      rd_d = {7'h00, clean_q[9]};
    else if (!on_page0)
      hit_d = 1'b0;
    else
    begin
      case (reg_addr[7:0])
        `CGR_OFS_DIE_REVISION: rd_d = {4'h0, DIE_REVISION};
        `CGR_OFS_PART_LOW: rd_d = BASE_PART_DIGITS[7:0];
        `CGR_OFS_PART_HIGH: rd_d = BASE_PART_DIGITS[15:8];
        `CGR_OFS_SPEED_GRADE: rd_d = SPEED_GRADE;
        `CGR_OFS_DEVICE_REV: rd_d = DEVICE_REVISION;
        `CGR_OFS_TOOL0: rd_d = TOOL_VERSION[7:0];
        `CGR_OFS_TOOL1: rd_d = TOOL_VERSION[15:8];
        `CGR_OFS_TOOL2: rd_d = TOOL_VERSION[23:16];
        `CGR_OFS_TEMP_GRADE: rd_d = TEMP_GRADE;
        `CGR_OFS_PACKAGE: rd_d = PACKAGE_CODE;
        `CGR_OFS_TARGET_ADDR: rd_d = {1'b0, addr_upper_q, 2'b00};
        `CGR_OFS_LIVE_STATUS: rd_d = live_fault_w;
        `CGR_OFS_INPUT_LOSS: rd_d = live_loss_w;
        `CGR_OFS_STICKY_FAULT: rd_d = sticky_fault_q;
        `CGR_OFS_STICKY_LOSS: rd_d = sticky_loss_q;
        `CGR_OFS_FAULT_MASK: rd_d = mask_q;
        default: hit_d = 1'b0;
      endcase
    end
  end
  // read data registered one cycle after the strobe
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= 8'h00;
      reg_addr_hit <= 1'b0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rd_d;
      reg_addr_hit <= hit_d;
    end
  end
endmodule

// file: testbench/cgr_regs_checker.sv
// assertion checker for the status and identification register page
`timescale 1ns/1ps
module cgr_regs_checker (
  input wire clock,
  input wire rstn,
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire reg_addr_hit,
  input wire [7:0] current_page,
  input wire calibration_in_progress,
  input wire [3:0] per_input_signal_loss,
  input wire device_ready,
  input wire address_select_pin_low,
  input wire [6:0] serial_target_address,
  input wire irq_n
);
  // ***********************************
  // shadows of the page zero fault mask and target address writables
  // ***********************************
  reg [7:0] mask_q;
  reg [7:0] upper_q;
  // track only what the design is allowed to take
  always @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      mask_q <= 8'h00;
      upper_q <= 8'h74;
    end
    else if (reg_wr && reg_addr == 16'h0017 && current_page == 8'h00)
      mask_q <= reg_wdata;
    else if (reg_wr && reg_addr == 16'h000b && current_page == 8'h00)
      upper_q <= reg_wdata;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_page_write: assert property (reg_wr && reg_addr == {current_page, 8'h01} |=>
    current_page == $past(reg_wdata)) else $error("page not taken");
  chk_page_read: assert property (reg_rd && reg_addr == {current_page, 8'h01} |=>
    reg_addr_hit && reg_rdata == $past(current_page)) else $error("page read wrong");
  chk_wrong_page: assert property (reg_rd && reg_addr[15:8] != current_page |=>
    !reg_addr_hit && reg_rdata == 8'h00) else $error("foreign page answered");
  chk_loss_live: assert property ($stable(per_input_signal_loss) [*6] ##0
    (reg_rd && reg_addr == 16'h000d && current_page == 8'h00) |=>
    reg_rdata[3:0] == $past(per_input_signal_loss)) else $error("loss bits wrong");
  chk_ready_read: assert property ($stable(device_ready) [*6] ##0
    (reg_rd && reg_addr == {current_page, 8'hff}) |=> reg_rdata[0] == $past(device_ready))
    else $error("ready bit wrong");
  chk_pin_bit: assert property ($stable(address_select_pin_low) [*8] |->
    serial_target_address[0] == address_select_pin_low) else $error("pin bit wrong");
  chk_upper_addr: assert property ($stable(upper_q) [*3] |->
    serial_target_address[6:2] == upper_q[6:2]) else $error("upper address wrong");
  chk_irq_raise: assert property (calibration_in_progress [*6] ##0 !mask_q[0] |->
    ##[0:3] !irq_n) else $error("interrupt missing");
  cover property (reg_wr && reg_addr[7:0] == 8'h01);
  cover property ($fell(irq_n));
  cover property (reg_rd && reg_addr[15:8] != current_page);
endmodule

// file: testbench/cgr_host.sv
// host controller model driving the register strobes
`timescale 1ns/1ps
module cgr_host (
  input wire clock,
  output reg [15:0] reg_addr,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_wdata
);
  // ***********************************
  // single strobe access
  // ***********************************
  initial
  begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // released lines are scrambled so stale values never pass
  task access(input w, input [15:0] a, input [7:0] d);
  begin
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  end
  endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the status and identification register page
`timescale 1ns/1ps
module tb;
  // ***********************************
  // stimulus, watcher and verdict
  // ***********************************
  reg clock, rstn, ready, pin_hi, pin_lo, seen;
  reg [4:0] fault;
  reg [3:0] loss;
  reg [7:0] v;
  reg [16:0] e;
  reg [16:0] expq[$];
  reg [31:0] rs = 32'h0000_43db;
  reg [7:0] idv [0:10] = '{8'h03, 8'h00, 8'h34, 8'h12, 8'h02, 8'h01, 8'he1, 8'hc3, 8'h5a, 8'h00, 8'h01};
  wire [15:0] reg_addr;
  wire reg_wr, reg_rd, reg_addr_hit, irq_n;
  wire [7:0] reg_wdata, reg_rdata, current_page;
  wire [6:0] serial_target_address;
  integer err_total = 0, n_compared = 0, i;
  cgr_host cgr_host_inst (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));
  cgr_regs #(.DIE_REVISION(4'h3), .SPEED_GRADE(8'h02), .DEVICE_REVISION(8'h01),
    .TOOL_VERSION(24'h5a_c3e1), .PACKAGE_CODE(8'h01)) cgr_regs_inst (.clock(clock), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_addr_hit(reg_addr_hit), .current_page(current_page), .calibration_in_progress(fault[0]),
    .crystal_input_signal_loss(fault[1]), .detector_reference_missing(fault[2]), .pll_unlocked(fault[3]),
    .bus_timeout(fault[4]), .per_input_signal_loss(loss), .device_ready(ready),
    .address_select_pin_high(pin_hi), .address_select_pin_low(pin_lo),
    .serial_target_address(serial_target_address), .irq_n(irq_n));
  function [31:0] xs;
  begin
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    xs = rs;
  end
  endfunction
  task chk(input [8:0] got, input [8:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  // note the expected answer, then let the host issue the read
  task rd(input [15:0] a, input [7:0] d, input [7:0] m, input h);
  begin
    expq.push_back({m, h, d});
    cgr_host_inst.access(1'b0, a, 8'h00);
  end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    cgr_host_inst.access(1'b1, a, d);
  endtask
  task wt(input integer n);
  begin
    repeat (n) @(posedge clock);
    #1;
  end
  endtask
  task summarize;
  begin
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // the answer lands on the edge after the strobe edge
  always @(posedge clock)
  begin
    #2;
    if (seen)
    begin
      e = expq.pop_front();
      chk({reg_addr_hit, reg_rdata & e[16:9]}, {e[8], e[7:0] & e[16:9]});
    end
    seen = reg_rd;
  end
  initial
  begin
    {rstn, seen, fault, loss, ready, pin_hi, pin_lo} = 14'h0004;
    wt(6);
    rstn = 1'b1;
    // identification bytes; writes must bounce off
    for (i = 0; i <= 10; i++)
    begin
      wr(i[15:0], (i == 1) ? 8'h00 : ~idv[i]);
      rd(i[15:0], idv[i], 8'hff, 1'b1);
    end
    rd(16'h000b, 8'h74, 8'hff, 1'b1);
    $display("test identification done");
    v = xs();
    wr(16'h0001, v);
    rd({v, 8'h01}, v, 8'hff, 1'b1);
    rd({v, 8'hff}, 8'h01, 8'h01, 1'b1);
    rd({~v, 8'h01}, 8'h00, 8'hff, 1'b0);
    wr({v, 8'h01}, 8'h00);
    v = xs();
    {pin_hi, pin_lo} = v[1:0];
    wr(16'h000b, v);
    rd(16'h000b, v & 8'h7c, 8'hff, 1'b1);
    wt(8);
    chk({2'b00, serial_target_address}, {2'b00, v[6:2], v[1:0]});
    $display("test page and address done");
    for (i = 0; i < 5; i++)
    begin
      fault = 5'h01 << i;
      v = 8'h01 << (i + i / 4); // status bit 4 is unused
      wt(8);
      chk({8'h00, irq_n}, 9'h000);
      rd(16'h000c, v, 8'hff, 1'b1);
      fault = 5'h00;
      wt(8);
      rd(16'h000c, 8'h00, 8'hff, 1'b1);
      wr(16'h0017, v);
      wt(2);
      chk({8'h00, irq_n}, 9'h001);
      wr(16'h0011, 8'hff);
      rd(16'h0011, v, 8'hff, 1'b1);
      wr(16'h0011, 8'h00);
      wr(16'h0017, 8'h00);
      rd(16'h0011, 8'h00, 8'hff, 1'b1);
      chk({8'h00, irq_n}, 9'h001);
    end
    $display("test faults done");
    v = xs();
    loss = v[3:0] | 4'h5;
    wt(8);
    rd(16'h000d, {4'h0, loss}, 8'hff, 1'b1);
    loss = 4'h0;
    wt(8);
    rd(16'h000d, 8'h00, 8'hff, 1'b1);
    wr(16'h0012, 8'hfa);
    rd(16'h0012, {4'h0, v[3:0] & 4'ha}, 8'h0f, 1'b1);
    $display("test input loss done");
    for (i = 0; i < 10 && expq.size() > 0; i++)
      @(posedge clock);
    if (expq.size() > 0)
      chk(9'h000, 9'h1ff);
    summarize;
  end
endmodule
bind cgr_regs cgr_regs_checker cgr_regs_checker_inst (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_addr_hit(reg_addr_hit), .current_page(current_page), .calibration_in_progress(calibration_in_progress),
  .per_input_signal_loss(per_input_signal_loss), .device_ready(device_ready),
  .address_select_pin_low(address_select_pin_low), .serial_target_address(serial_target_address),
  .irq_n(irq_n));
